// ---- logic/adcsq_pkg.sv ----
// Constants, field positions and carrier types of the converter sequencer.
// Assumes a 32-bit APB register bus and a 16-input analog front end.
package adcsq_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [7:0] ADCSQ_OFF_CTRL1  = 8'h00;  // control_register_1
	localparam logic [7:0] ADCSQ_OFF_CTRL2  = 8'h04;  // control_register_2
	localparam logic [7:0] ADCSQ_OFF_CTRL3  = 8'h08;  // control_register_3
	localparam logic [7:0] ADCSQ_OFF_CHSEL  = 8'h0c;  // channel_select_register
	localparam logic [7:0] ADCSQ_OFF_SCAN   = 8'h10;  // scan_list_select
	localparam logic [7:0] ADCSQ_OFF_PCFG   = 8'h14;  // pin_config_register
	localparam logic [7:0] ADCSQ_OFF_RESULT = 8'h18;  // Last conversion result, read only
	localparam logic [7:0] ADCSQ_OFF_IRQ    = 8'h1c;  // Interrupt flag and priority

	////////////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int ADCSQ_C1_ON    = 15;  // Module on
	localparam int ADCSQ_C1_SSRC  = 5;   // Conversion trigger source, 3 bits
	localparam int ADCSQ_C1_AUTO_SAMPLE_ENABLE  = 2;   // auto_sample_enable
	localparam int ADCSQ_C1_SAMPLE_BIT  = 1;   // sample_bit
	localparam int ADCSQ_C1_DONE  = 0;   // Conversion complete
	localparam int ADCSQ_C2_VCFG  = 13;  // Reference selection, 3 bits
	localparam int ADCSQ_C2_SCAN_ENABLE = 10;  // scan_enable
	localparam int ADCSQ_C2_SMPI  = 2;   // Conversions per interrupt minus one, 4 bits
	localparam int ADCSQ_C2_ALTERNATE_INPUT_ENABLE  = 0;   // alternate_input_enable
	localparam int ADCSQ_C3_AUTO_SAMPLE_TIME  = 8;   // auto_sample_time, 5 bits
	localparam int ADCSQ_C3_ADCS  = 0;   // Conversion clock divisor, 8 bits
	localparam int ADCSQ_CH_NA    = 23;  // Mux A negative select
	localparam int ADCSQ_CH_SA    = 16;  // mux_a_positive_select, 4 bits
	localparam int ADCSQ_CH_NB    = 31;  // Mux B negative select
	localparam int ADCSQ_CH_SB    = 24;  // mux_b_positive_select, 4 bits
	localparam int ADCSQ_IRQ_FLAG = 0;   // converter_interrupt_flag
	localparam int ADCSQ_IRQ_PRIO = 8;   // converter_irq_priority, 3 bits

	////////////////////////////////////////////////////////////////////////////////
	// Reset values and codes
	localparam logic [15:0] ADCSQ_RST_CTRL  = 16'h0000;
	localparam logic [31:0] ADCSQ_RST_CHSEL = 32'h0000_0000;
	localparam logic [15:0] ADCSQ_RST_PCFG  = 16'h0000;
	localparam logic [2:0]  ADCSQ_RST_PRIO  = 3'h4;
	localparam logic [2:0]  ADCSQ_SSRC_AUTO = 3'h7;  // Internal counter ends sampling
	localparam logic [4:0]  ADCSQ_AUTO_SAMPLE_TIME_MIN  = 5'h01; // Least acquisition, one conversion clock

	////////////////////////////////////////////////////////////////////////////////
	// Carrier types
	typedef enum logic [1:0] {ADCSQ_IDLE, ADCSQ_SAMPLE, ADCSQ_CONVERT} adcsq_state_t;

	typedef struct packed {
		logic       sample_en;      // Sample switch closed, hold capacitor tracking
		logic       convert_start;  // One-cycle pulse, begin conversion
		logic [3:0] pos_sel;        // Positive input number
		logic       neg_sel;        // 0: low reference, 1: input 1
		logic [2:0] vref_sel;       // 0: analog supply rails
	} adcsq_afe_req_t;

	typedef struct packed {
		logic       done;           // One-cycle pulse, conversion finished
		logic [9:0] result;         // Valid with done
	} adcsq_afe_rsp_t;

endpackage : adcsq_pkg

// ---- logic/adcsq_clkdiv.sv ----
// Conversion clock generator: divides pclk by 2*(divisor+1).
// Assumes the divisor is static while the module is on.
`timescale 1ns/1ps
module adcsq_clkdiv
	import adcsq_pkg::*;
#(
	parameter int DIV_W = 8
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             ce,
	input  wire logic             run,
	input  wire logic [DIV_W-1:0] divisor,
	output logic                  conv_clk,
	output logic                  tad_tick
);

	logic [DIV_W-1:0] cnt_q;   // Half-period counter
	logic             clk_q;   // Divided clock level
	logic             tick_q;  // One pulse per full period
	wire              half_end = (cnt_q == divisor);

	////////////////////////////////////////////////////////////////////////////////
	// Divider; all-zero divisor gives half the bus rate
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q  <= '0;
			clk_q  <= 1'b0;
			tick_q <= 1'b0;
		end else if (ce) begin
			if (!run) begin
				// Stopped divider restarts in phase
				cnt_q  <= '0;
				clk_q  <= 1'b0;
				tick_q <= 1'b0;
			end else begin
				cnt_q  <= half_end ? '0 : cnt_q + 1'b1;
				clk_q  <= half_end ? ~clk_q : clk_q;
				tick_q <= half_end & clk_q;
			end
		end
	end

	assign conv_clk = clk_q;
	assign tad_tick = tick_q;

endmodule : adcsq_clkdiv

// ---- logic/adcsq_seq.sv ----
// Sequencer and APB register file of a 10-bit successive-approximation converter.
// Assumes the analog core answers each convert_start with one done pulse.
//
// Overview of operation
// - Alternate mode: mux A sample, then mux B
// - Scan plus alternate: mux A from scan list
// - Mux B positive input from bits 27:24
// - Auto sample clear: only sample bit starts
// - Manual start ignores auto sample time field
// - Manual trigger: clearing sample bit ends acquisition, starts conversion
// - Sequence end sets done; interrupt flag when fill count meets fill setting
// - Scan list ignored while scan disabled
// - Zero fill setting: interrupt every conversion
// - Zero reference field selects analog supply rails
// - Zero channel select: input 0, low reference
// - Interrupt priority resets to level 4
// - 8000 hex turns on, 0002 starts sampling
// - Zero control 3: conversion clock half bus
// - One pin configuration bit per input, clear=analog
// - Alternate bit switches between mux A and mux B selections
// - Scan steps through selected inputs in order
`timescale 1ns/1ps
module adcsq_seq
	import adcsq_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter int N_IN   = 16
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              ce,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	output adcsq_afe_req_t         afe_req,
	input  wire adcsq_afe_rsp_t    afe_rsp,
	output logic                   conv_clk,
	output logic      [N_IN-1:0]   analog_pin_enable,
	output logic                   converter_interrupt_flag,
	output logic      [2:0]        converter_irq_priority
);

	////////////////////////////////////////////////////////////////////////////////
	// Registers
	logic [15:0]    ctrl1_q, ctrl1_d;   // control_register_1
	logic [15:0]    ctrl2_q;            // control_register_2
	logic [15:0]    ctrl3_q;            // control_register_3
	logic [31:0]    chsel_q;            // channel_select_register
	logic [N_IN-1:0] scan_q;            // scan_list_select
	logic [N_IN-1:0] pcfg_q;            // pin_config_register
	logic [9:0]     result_q;           // Last conversion result
	logic           iflag_q, iflag_d;   // converter_interrupt_flag
	logic [2:0]     prio_q;             // converter_irq_priority
	adcsq_state_t   state_q, state_d;   // Sequencer state
	logic           alt_b_q;            // Next sample uses mux B
	logic [3:0]     scan_idx_q;         // Scan search start point
	logic [3:0]     fill_cnt_q;         // Conversions since last interrupt
	logic [4:0]     auto_sample_time_cnt_q;         // Conversion clocks spent sampling
	adcsq_afe_req_t afe_q;              // Registered front-end request
	logic           pready_q;           // Second access cycle marker
	logic [31:0]    prdata_q;           // Captured read data
	logic           pslverr_q;          // Captured error answer

	////////////////////////////////////////////////////////////////////////////////
	// Named control fields
	wire       on_bit    = ctrl1_q[ADCSQ_C1_ON];
	wire [2:0] ssrc      = ctrl1_q[ADCSQ_C1_SSRC +: 3];
	wire       auto_sample_enable      = ctrl1_q[ADCSQ_C1_AUTO_SAMPLE_ENABLE];
	wire       sample_bit      = ctrl1_q[ADCSQ_C1_SAMPLE_BIT];
	wire       alternate_input_enable      = ctrl2_q[ADCSQ_C2_ALTERNATE_INPUT_ENABLE];
	wire       scan_en   = ctrl2_q[ADCSQ_C2_SCAN_ENABLE];
	wire [3:0] smpi      = ctrl2_q[ADCSQ_C2_SMPI +: 4];
	wire [2:0] vcfg      = ctrl2_q[ADCSQ_C2_VCFG +: 3];
	wire [4:0] auto_sample_time      = ctrl3_q[ADCSQ_C3_AUTO_SAMPLE_TIME +: 5];
	wire [7:0] adcs      = ctrl3_q[ADCSQ_C3_ADCS +: 8];
	wire       auto_conv = (ssrc == ADCSQ_SSRC_AUTO);

	////////////////////////////////////////////////////////////////////////////////
	// APB decode; access answered on its second cycle so read data comes from a flop
	wire access   = psel & penable;
	wire accept   = access & pready_q;
	wire hit_c1   = (paddr == ADCSQ_OFF_CTRL1);
	wire hit_c2   = (paddr == ADCSQ_OFF_CTRL2);
	wire hit_c3   = (paddr == ADCSQ_OFF_CTRL3);
	wire hit_ch   = (paddr == ADCSQ_OFF_CHSEL);
	wire hit_sc   = (paddr == ADCSQ_OFF_SCAN);
	wire hit_pc   = (paddr == ADCSQ_OFF_PCFG);
	wire hit_rs   = (paddr == ADCSQ_OFF_RESULT);
	wire hit_iq   = (paddr == ADCSQ_OFF_IRQ);
	wire mapped   = hit_c1 | hit_c2 | hit_c3 | hit_ch | hit_sc | hit_pc | hit_rs | hit_iq;
	wire wr_ok    = accept & pwrite & mapped;
	wire wr_c1    = wr_ok & hit_c1;
	wire wr_iq    = wr_ok & hit_iq;

	// Read selection; reserved bits read as zero
	wire [31:0] rd_mux =
		hit_c1 ? {16'h0000, ctrl1_q} :
		hit_c2 ? {16'h0000, ctrl2_q} :
		hit_c3 ? {16'h0000, ctrl3_q} :
		hit_ch ? chsel_q :
		hit_sc ? {{(32-N_IN){1'b0}}, scan_q} :
		hit_pc ? {{(32-N_IN){1'b0}}, pcfg_q} :
		hit_rs ? {22'h0, result_q} :
		hit_iq ? {21'h0, prio_q, 7'h00, iflag_q} : 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////////////
	// Scan list search: first selected input at or after the start point
	function automatic logic [3:0] scan_find(input logic [N_IN-1:0] list,
	                                         input logic [3:0] start);
		logic [3:0] pick;
		logic       found;
		logic [3:0] j;
		pick  = start;
		found = 1'b0;
		for (int i = 0; i < N_IN; i++) begin
			j = start + 4'(i);
			if (!found && list[j]) begin
				pick  = j;
				found = 1'b1;
			end
		end
		return pick;
	endfunction : scan_find

	wire [3:0] scan_cur = scan_find(scan_q, scan_idx_q);

	////////////////////////////////////////////////////////////////////////////////
	// Input selection for the sample in progress
	wire       use_b   = alternate_input_enable & alt_b_q;
	wire [3:0] a_pos   = scan_en ? scan_cur : chsel_q[ADCSQ_CH_SA +: 4];
	wire [3:0] pos_sel = use_b ? chsel_q[ADCSQ_CH_SB +: 4] : a_pos;
	wire       neg_sel = use_b ? chsel_q[ADCSQ_CH_NB] : chsel_q[ADCSQ_CH_NA];

	////////////////////////////////////////////////////////////////////////////////
	// Conversion clock
	wire tad_tick;

	adcsq_clkdiv #(
		.DIV_W    (8)
	) u_clkdiv (
		.pclk     (pclk),
		.presetn  (presetn),
		.ce       (ce),
		.run      (on_bit),
		.divisor  (adcs),
		.conv_clk (conv_clk),
		.tad_tick (tad_tick)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer events
	wire [4:0] auto_sample_time_eff  = (auto_sample_time == 5'h00) ? ADCSQ_AUTO_SAMPLE_TIME_MIN : auto_sample_time;
	wire auto_sample_time_done       = tad_tick & (auto_sample_time_cnt_q + 5'h01 >= auto_sample_time_eff);
	// Auto trigger counts conversion clocks; manual trigger waits for software
	wire end_sample      = (state_q == ADCSQ_SAMPLE) &
	                       (auto_conv ? auto_sample_time_done : ~sample_bit);
	wire conv_done       = (state_q == ADCSQ_CONVERT) & afe_rsp.done;
	wire fill_hit        = (fill_cnt_q == smpi);

	////////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ADCSQ_IDLE: begin
				// Sampling starts only from the sample bit
				if (on_bit && sample_bit) state_d = ADCSQ_SAMPLE;
			end
			ADCSQ_SAMPLE: begin
				if (end_sample) state_d = ADCSQ_CONVERT;
			end
			ADCSQ_CONVERT: begin
				if (afe_rsp.done) state_d = ADCSQ_IDLE;
			end
		endcase
		// Switching the module off abandons any sequence
		if (!on_bit) state_d = ADCSQ_IDLE;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control register 1 next value; hardware updates win over a same-cycle write
	always_comb begin
		ctrl1_d = ctrl1_q;
		if (wr_c1) ctrl1_d = pwdata[15:0];
		// Auto trigger drops the sample bit when its count expires
		if (end_sample && auto_conv) ctrl1_d[ADCSQ_C1_SAMPLE_BIT] = 1'b0;
		if (conv_done) begin
			ctrl1_d[ADCSQ_C1_DONE] = 1'b1;
			// Without auto sample the bit stays clear after completion
			if (auto_sample_enable) ctrl1_d[ADCSQ_C1_SAMPLE_BIT] = 1'b1;
		end
	end

	// Interrupt flag: set wins over a software clear in the same cycle
	always_comb begin
		iflag_d = iflag_q;
		if (wr_iq && pwdata[ADCSQ_IRQ_FLAG]) iflag_d = 1'b0;               // Write one to clear
		if (conv_done && fill_hit) iflag_d = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register file
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl1_q <= ADCSQ_RST_CTRL;
			ctrl2_q <= ADCSQ_RST_CTRL;
			ctrl3_q <= ADCSQ_RST_CTRL;
			chsel_q <= ADCSQ_RST_CHSEL;
			scan_q  <= '0;
			pcfg_q  <= ADCSQ_RST_PCFG;
			iflag_q <= 1'b0;
			prio_q  <= ADCSQ_RST_PRIO;
		end else if (ce) begin
			ctrl1_q <= ctrl1_d;
			iflag_q <= iflag_d;
			if (wr_ok && hit_c2) ctrl2_q <= pwdata[15:0];
			if (wr_ok && hit_c3) ctrl3_q <= pwdata[15:0];
			if (wr_ok && hit_ch) chsel_q <= pwdata;
			if (wr_ok && hit_sc) scan_q  <= pwdata[N_IN-1:0];
			if (wr_ok && hit_pc) pcfg_q  <= pwdata[N_IN-1:0];
			if (wr_iq) prio_q <= pwdata[ADCSQ_IRQ_PRIO +: 3];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer state and sample counting
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q    <= ADCSQ_IDLE;
			auto_sample_time_cnt_q <= '0;
		end else if (ce) begin
			state_q <= state_d;
			// Count restarts with every new acquisition
			if (state_q != ADCSQ_SAMPLE) auto_sample_time_cnt_q <= '0;
			else if (tad_tick) auto_sample_time_cnt_q <= auto_sample_time_cnt_q + 5'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Mux alternation, scan stepping and fill counting, all per finished conversion
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alt_b_q    <= 1'b0;
			scan_idx_q <= '0;
			fill_cnt_q <= '0;
			result_q   <= '0;
		end else if (ce) begin
			if (!on_bit) begin
				// Off restarts the pattern at mux A and the scan at its head
				alt_b_q    <= 1'b0;
				scan_idx_q <= '0;
				fill_cnt_q <= '0;
			end else if (conv_done) begin
				result_q   <= afe_rsp.result;
				alt_b_q    <= alternate_input_enable ? ~alt_b_q : 1'b0;
				// Scan steps only on mux A samples
				if (scan_en && !use_b) scan_idx_q <= scan_cur + 4'h1;
				fill_cnt_q <= fill_hit ? 4'h0 : fill_cnt_q + 4'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Front-end request, registered so the selection is glitch free at the switch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			afe_q <= '0;
		end else if (ce) begin
			afe_q.sample_en     <= (state_d == ADCSQ_SAMPLE);
			afe_q.convert_start <= end_sample;
			afe_q.pos_sel       <= pos_sel;
			afe_q.neg_sel       <= neg_sel;
			afe_q.vref_sel      <= vcfg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// APB answer: one wait cycle, then pready with registered data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			prdata_q  <= '0;
			pslverr_q <= 1'b0;
		end else if (ce) begin
			pready_q  <= access & ~pready_q;
			if (access && !pready_q) begin
				prdata_q  <= pwrite ? 32'h0000_0000 : rd_mux;
				pslverr_q <= ~mapped;
			end
		end
	end

	// Ready held low while frozen so no transfer completes unseen
	assign pready  = pready_q & ce;
	assign prdata  = prdata_q;
	assign pslverr = pslverr_q & pready_q;

	////////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign afe_req                  = afe_q;
	// Clear bit selects analog, matching the all-zero all-analog setup
	assign analog_pin_enable        = ~pcfg_q;
	assign converter_interrupt_flag = iflag_q;
	assign converter_irq_priority   = prio_q;

endmodule : adcsq_seq

// ---- tb/adcsq_seq_properties.sv ----
// Concurrent checks on the converter sequencer, bound to its top module.
// Assumes ce is held high and the analog core answers each start once.
`timescale 1ns/1ps
module adcsq_seq_properties
	import adcsq_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter int N_IN   = 16
) (
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              ce,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire adcsq_afe_req_t    afe_req,
	input wire adcsq_afe_rsp_t    afe_rsp,
	input wire logic              conv_clk,
	input wire logic [N_IN-1:0]   analog_pin_enable,
	input wire logic              converter_interrupt_flag,
	input wire logic [2:0]        converter_irq_priority
);
	////////////////////////////////////////////////////////////////////////////////
	logic        wr_c1;  // Write landing on control 1
	logic        wr_pc;  // Write landing on pin configuration
	logic [15:0] c1_q;   // Shadow of written control 1; only software sets ON, SSRC, AUTO_SAMPLE_ENABLE
	assign wr_c1 = psel && penable && pready && pwrite && paddr == ADCSQ_OFF_CTRL1;
	assign wr_pc = psel && penable && pready && pwrite && paddr == ADCSQ_OFF_PCFG;
	// Shadow follows software writes only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			c1_q <= 16'h0000;
		else if (wr_c1)
			c1_q <= pwdata[15:0];
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////////////////////
	AST_PRIO_RST: assert property (!$past(presetn) |-> converter_irq_priority == 3'h4)
		else $error("priority not level 4 after reset");
	AST_SEL_RST: assert property (!$past(presetn) |-> afe_req.pos_sel == 4'h0 &&
		!afe_req.neg_sel && afe_req.vref_sel == 3'h0) else $error("reset selection wrong");
	AST_PIN_MAP: assert property (wr_pc |=> analog_pin_enable == ~$past(pwdata[15:0]))
		else $error("pin enable not inverse of config");
	AST_START_ONE: assert property (afe_req.convert_start |=> !afe_req.convert_start)
		else $error("convert start longer than one cycle");
	AST_START_CAUSE: assert property ($rose(afe_req.convert_start) && c1_q[7:5] != 3'h7
		|-> $past(wr_c1, 2) && $past(afe_req.sample_en) && !afe_req.sample_en)
		else $error("manual conversion without sample clear");
	AST_MANUAL_START: assert property ($rose(afe_req.sample_en) && !c1_q[2]
		|-> $past(wr_c1 && pwdata[1], 2)) else $error("sampling started without sample bit");
	// The request is registered, so a clearing write shows two edges later
	AST_SAMPLE_HELD: assert property (afe_req.sample_en && c1_q[7:5] != 3'h7 &&
		!wr_c1 && !$past(wr_c1)
		|=> afe_req.sample_en) else $error("manual sampling ended on its own");
	AST_FLAG_CAUSE: assert property ($rose(converter_interrupt_flag) |-> $past(afe_rsp.done))
		else $error("flag raised without conversion end");
	AST_CLK_OFF: assert property (!c1_q[15] |=> !conv_clk)
		else $error("conversion clock runs while off");
	COV_DONE: cover property (afe_rsp.done);
	COV_FLAG: cover property ($rose(converter_interrupt_flag));
	COV_ERR: cover property (pslverr && pready);
endmodule : adcsq_seq_properties

bind adcsq_seq adcsq_seq_properties #(.ADDR_W(ADDR_W), .N_IN(N_IN)) u_props (
	.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .afe_req(afe_req), .afe_rsp(afe_rsp), .conv_clk(conv_clk),
	.analog_pin_enable(analog_pin_enable),
	.converter_interrupt_flag(converter_interrupt_flag),
	.converter_irq_priority(converter_irq_priority)
);

// ---- tb/adcsq_afe_model.sv ----
// Behavioural analog core: one done pulse a set number of cycles after each start.
// Assumes lat is at least one; result lines churn when no result is held.
`timescale 1ns/1ps
module adcsq_afe_model
	import adcsq_pkg::*;
(
	input  wire logic           pclk,
	input  wire logic           presetn,
	input  wire logic [7:0]     lat,
	input  wire adcsq_afe_req_t afe_req,
	output adcsq_afe_rsp_t      afe_rsp
);
	////////////////////////////////////////////////////////////////////////////////
	logic [7:0] cnt_q;   // Cycles left in conversion, zero when idle
	logic [9:0] code_q;  // Code taken from the selection at start
	// Conversion timer; result inverted each idle cycle so stale data never matches
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q   <= 8'h00;
			code_q  <= 10'h000;
			afe_rsp <= '0;
		end else begin
			afe_rsp.done   <= 1'b0;
			afe_rsp.result <= ~afe_rsp.result;
			if (afe_req.convert_start) begin
				cnt_q  <= lat;
				code_q <= {afe_req.pos_sel, 3'h5, afe_req.vref_sel};
			end else if (cnt_q == 8'h01) begin
				cnt_q   <= 8'h00;
				afe_rsp <= {1'b1, code_q};
			end else if (cnt_q != 8'h00) begin
				cnt_q <= cnt_q - 8'h01;
			end
		end
	end
endmodule : adcsq_afe_model

// ---- tb/testbench.sv ----
// Self-checking bench of the converter sequencer over APB.
// Assumes the one-wait APB slave and manual trigger use only.
`timescale 1ns/1ps
module testbench;
	import adcsq_pkg::*;
	////////////////////////////////////////////////////////////////////////////////
	logic           pclk, presetn, ce, psel, penable, pwrite;  // Bus and clocking
	logic [7:0]     paddr, lat;                                // Address, core latency
	logic [31:0]    pwdata, prdata, rv;                        // Data and last read
	logic           pready, pslverr, re, conv_clk, flag;       // Answers
	logic [15:0]    pin_en;                                    // Analog pin enables
	logic [2:0]     prio;                                      // Interrupt priority
	adcsq_afe_req_t afe_req;                                   // To analog core
	adcsq_afe_rsp_t afe_rsp;                                   // From analog core
	int             error_cnt, checks;                         // Verdict counters
	adcsq_seq DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .afe_req(afe_req), .afe_rsp(afe_rsp), .conv_clk(conv_clk),
		.analog_pin_enable(pin_en), .converter_interrupt_flag(flag),
		.converter_irq_priority(prio));
	adcsq_afe_model u_afe (.pclk(pclk), .presetn(presetn), .lat(lat), .afe_req(afe_req),
		.afe_rsp(afe_rsp));
	always #5 pclk = ~pclk;  // 100 MHz
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// One APB transfer; holds the request until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		// A transfer that never completes counts as a mismatch
		if (pready !== 1'b1) error_cnt++;
		rv = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// One manual conversion, judged on selection, result, done and flag
	task automatic conv(input logic [3:0] p, input logic ng);
		int n;
		apb(1'b1, ADCSQ_OFF_CTRL1, 32'h8002);
		n = 0;
		while (afe_req.sample_en !== 1'b1 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		chk(32'(afe_req.pos_sel), 32'(p));
		chk(32'(afe_req.neg_sel), 32'(ng));
		repeat (4) @(posedge pclk);  // Acquisition time before ending sampling
		apb(1'b1, ADCSQ_OFF_CTRL1, 32'h8000);
		n = 0;
		while (flag !== 1'b1 && n < 200) begin
			@(posedge pclk);
			n++;
		end
		chk(32'(flag), 32'h1);
		apb(1'b0, ADCSQ_OFF_CTRL1, 32'h0);
		chk(rv, 32'h8001);
		apb(1'b0, ADCSQ_OFF_RESULT, 32'h0);
		chk(rv, {22'h0, p, 6'h28});
		apb(1'b1, ADCSQ_OFF_IRQ, 32'h1);
		@(posedge pclk);
		chk(32'(flag), 32'h0);
	endtask : conv
	////////////////////////////////////////////////////////////////////////////////
	// Reset values, register table and an unmapped place
	task automatic t_reset;
		chk(32'(prio), 32'h4);
		chk(32'(pin_en), 32'hffff);
		chk(32'(afe_req), 32'h0);
		chk(32'(conv_clk), 32'h0);
		for (int i = 0; i < 8; i++) begin
			apb(1'b0, 8'(4 * i), 32'h0);
			chk(rv, (i == 7) ? 32'h400 : 32'h0);
		end
		apb(1'b1, 8'h20, 32'hffff_ffff);
		chk({31'h0, re}, 32'h1);
		apb(1'b1, ADCSQ_OFF_PCFG, 32'h00f0);  // Driver already off
		@(posedge pclk);
		chk(32'(pin_en), 32'hff0f);
		apb(1'b1, ADCSQ_OFF_PCFG, 32'h0);
	endtask : t_reset
	// Scan list with alternation: mux A walks the list, mux B fixed
	task automatic t_scan;
		logic [27:0] seq;
		seq = 28'h2959b92;
		lat = 8'd2;
		apb(1'b1, ADCSQ_OFF_SCAN, 32'h0824);
		apb(1'b1, ADCSQ_OFF_CHSEL, 32'h8907_0000);
		apb(1'b1, ADCSQ_OFF_CTRL2, 32'h0401);
		apb(1'b1, ADCSQ_OFF_CTRL3, 32'h0009);  // Conversion clock period 200 ns
		for (int i = 0; i < 7; i++)
			conv(seq[27-4*i -: 4], i[0]);
		apb(1'b1, ADCSQ_OFF_CTRL1, 32'h0);
	endtask : t_scan
	// Manual sampling ignores sample time, slow core, no restart
	task automatic t_manual;
		int lo, same;
		logic prev;
		lo = 0;
		same = 0;
		lat = 8'd9;
		apb(1'b1, ADCSQ_OFF_CTRL2, 32'h0);
		apb(1'b1, ADCSQ_OFF_CHSEL, 32'h0003_0000);
		apb(1'b1, ADCSQ_OFF_CTRL3, 32'h1f00);
		apb(1'b1, ADCSQ_OFF_CTRL1, 32'h8002);
		repeat (3) @(posedge pclk);
		prev = conv_clk;
		repeat (100) begin
			@(posedge pclk);
			lo += (afe_req.sample_en !== 1'b1);
			same += (conv_clk === prev);
			prev = conv_clk;
		end
		chk(32'(lo), 32'h0);
		chk(32'(same), 32'h0);
		conv(4'h3, 1'b0);
		repeat (40) @(posedge pclk);
		chk(32'(afe_req.sample_en), 32'h0);
	endtask : t_manual
	////////////////////////////////////////////////////////////////////////////////
	task automatic end_sim;
		$display("checks=%0d error_cnt=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim
	// Main sequence
	initial begin
		{pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{error_cnt, checks} = '0;
		ce = 1'b1;
		lat = 8'd2;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_scan();
		t_manual();
		end_sim();
	end
	// Watchdog at 40000 cycles, well beyond the few hundred cycles the tests need
	initial begin
		#400000;
		error_cnt++;
		end_sim();
	end
endmodule : testbench
